/* File: bench/host_link_model.sv */
`timescale 1ns/1ps

module host_link_model
  import sensor_pkg::*;
(
  output logic      sck,
  output logic      pull_low,
  input  wire logic data
);

  // ----------------------------------------
  // idle: clock parked low, data released
  // ----------------------------------------
  initial
  begin
    sck = 1'b0;
    pull_low = 1'b0;
  end

  // one clock: bit set after fall, sampled at rise
  task automatic pulse(input logic drive_low, output logic seen);
    pull_low = drive_low;
    #80;
    sck = 1'b1;
    seen = data;
    #45;
    sck = 1'b0;
  endtask

  task automatic start();
    // low phase first so the previous pulse's fall is seen
    #80;
    sck = 1'b1;
    #45;
    pull_low = 1'b1;
    #45;
    sck = 1'b0;
    #80;
    sck = 1'b1;
    #45;
    pull_low = 1'b0;
    #45;
    sck = 1'b0;
  endtask

  task automatic put(input byte_t b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      pulse(~b[i], s);
    pulse(1'b0, ack);
  endtask

  // ack_low low continues the transfer, high ends it
  task automatic get(input logic ack_low, output byte_t b);
    logic s;
    for (int i = 7; i >= 0; i--)
      pulse(1'b0, b[i]);
    pulse(~ack_low, s);
    pull_low = 1'b0;
  endtask

  task automatic idle_clocks(input int n);
    logic s;
    repeat (n) pulse(1'b0, s);
  endtask

endmodule

/* File: bench/tb.sv */
`timescale 1ns/1ps

module tb;
  import sensor_pkg::*;

  localparam int T8  = 200;
  localparam int T12 = 800;
  localparam int T14 = 3200;
  // settle time at the same scale of ten clocks per millisecond
  localparam int T_PWR = 110;

  logic  clock, reset_n, sck, pull_low, data_wire, data_out, data_oe, low_supply;
  logic  adc_valid, adc_ready, conv_start, conv_humid, conv_low_res, otp_reload, heater_on;
  word_t adc_data;
  int    error_cnt, checks_done, starts, reloads;
  byte_t bad [3] = '{8'h23, 8'h0a, 8'h1f};

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // open-drain wire with pull-up
  assign data_wire = (data_oe ? data_out : 1'b1) & ~pull_low;

  sensor_serial_if #(.MEAS_8_CYC(T8), .MEAS_12_CYC(T12), .MEAS_14_CYC(T14)) sensor_serial_if_i (
    .clock(clock), .reset_n(reset_n), .sck(sck), .data_in(data_wire),
    .data_out(data_out), .data_oe(data_oe), .low_supply(low_supply),
    .adc_valid(adc_valid), .adc_ready(adc_ready), .adc_data(adc_data),
    .conv_start(conv_start), .conv_humid(conv_humid), .conv_low_res(conv_low_res),
    .otp_reload(otp_reload), .heater_on(heater_on));

  host_link_model host_link_model_i (.sck(sck), .pull_low(pull_low), .data(data_wire));

  always @(posedge clock)
  begin
    if (conv_start === 1'b1)
      starts <= starts + 1;
    if (otp_reload === 1'b1)
      reloads <= reloads + 1;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic bail(input string what);
    chk(1'b0, 1'b1, what);
    conclude();
  endtask

  function automatic byte_t crc_of(input logic [31:0] bits, input int n);
    byte_t c;
    logic  fb;
    c = 8'h00;
    for (int i = n - 1; i >= 0; i--)
    begin
      fb = c[7] ^ bits[i];
      c = {c[6:0], 1'b0} ^ (fb ? 8'h31 : 8'h00);
    end
    return {<<{c}};
  endfunction

  task automatic cmd(input byte_t c, input logic exp_ack);
    logic a;
    host_link_model_i.start();
    host_link_model_i.put(c, a);
    chk(a, exp_ack, "command ack");
  endtask

  task automatic push(input word_t w);
    int n;
    n = 0;
    @(negedge clock);
    while (adc_ready !== 1'b1 && n < 100)
    begin
      @(negedge clock);
      n++;
    end
    if (n == 100)
      bail("converter stalled");
    adc_valid = 1'b1;
    adc_data = w;
    @(negedge clock);
    adc_valid = 1'b0;
  endtask

  task automatic measure(input byte_t c, input word_t exp, input logic use_crc);
    byte_t hi, lo, crc;
    int    n;
    cmd(c, 1'b0);
    n = 0;
    // let the ack release land first
    repeat (10) @(negedge clock);
    while (data_wire !== 1'b0 && n < T14 + 100)
    begin
      @(negedge clock);
      n++;
    end
    if (n == T14 + 100)
      bail("no ready");
    repeat (300) @(negedge clock);
    chk(data_wire, 1'b0, "ready held");
    host_link_model_i.get(1'b0, hi);
    host_link_model_i.get(~use_crc, lo);
    if (use_crc)
    begin
      host_link_model_i.get(1'b1, crc);
      chk(crc, crc_of({c, hi, lo}, 24), "result crc");
    end
    chk({hi, lo}, exp, "result");
    repeat (10) @(negedge clock);
    chk(data_oe, 1'b0, "sleep");
    repeat (9 * (n + 10)) @(negedge clock);
  endtask

  task automatic stat_rd(input byte_t exp, input byte_t mask);
    byte_t s, crc;
    cmd(8'h07, 1'b0);
    host_link_model_i.get(1'b0, s);
    host_link_model_i.get(1'b1, crc);
    chk(s & mask, exp, "status");
    chk(crc, crc_of({8'h07, s}, 16), "status crc");
  endtask

  task automatic stat_wr(input byte_t v);
    logic a;
    cmd(8'h06, 1'b0);
    host_link_model_i.put(v, a);
    chk(a, 1'b0, "write ack");
    repeat (10) @(negedge clock);
    chk(data_wire, 1'b1, "ack released");
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    adc_valid = 1'b0;
    adc_data = 16'h0000;
    low_supply = 1'b0;
    reset_n = 1'b0;
    error_cnt = 0;
    checks_done = 0;
    starts = 0;
    reloads = 0;
    repeat (3) @(posedge clock);
    @(negedge clock);
    reset_n = 1'b1;
    repeat (T_PWR) @(negedge clock);
    foreach (bad[i])
      cmd(bad[i], 1'b1);
    $display("test refusals done");
    push(16'hd5a7);
    push(16'hbeef);
    @(negedge clock);
    chk(adc_ready, 1'b0, "buffer full");
    measure(8'h03, 16'h15a7, 1'b1);
    chk(16'(starts), 16'd1, "starts");
    chk(16'(reloads), 16'd1, "reloads");
    chk(conv_humid, 1'b0, "temp mode");
    measure(8'h05, 16'h0eef, 1'b0);
    chk(conv_humid, 1'b1, "humid mode");
    chk(adc_ready, 1'b1, "buffer drained");
    $display("test measurements done");
    stat_wr(8'h07);
    chk({heater_on, conv_low_res}, 2'b11, "heater res");
    stat_rd(8'h07, 8'hff);
    push(16'h1234);
    measure(8'h05, 16'h0034, 1'b1);
    chk(16'(reloads), 16'd2, "no reload");
    $display("test status done");
    @(negedge clock);
    low_supply = 1'b1;
    measure(8'h03, 16'h0000, 1'b1);
    stat_rd(8'h47, 8'hff);
    $display("test timeout done");
    host_link_model_i.idle_clocks(9);
    stat_rd(8'h47, 8'hff);
    $display("test link reset done");
    cmd(8'h1e, 1'b0);
    repeat (T_PWR) @(negedge clock);
    chk({heater_on, conv_low_res}, 2'b00, "defaults");
    stat_rd(8'h00, 8'hbf);
    $display("test soft reset done");
    conclude();
  end

endmodule

/* File: rtl/sensor_pkg.sv */
package sensor_pkg;

  typedef enum logic [2:0]
  {
    ST_IDLE  = 3'b000,
    ST_CMD   = 3'b001,
    ST_ACK   = 3'b010,
    ST_MEAS  = 3'b011,
    ST_TX    = 3'b100,
    ST_RX    = 3'b101,
    ST_RXACK = 3'b110
  } state_e;

  typedef logic [15:0] word_t;
  typedef logic [7:0]  byte_t;

endpackage

/* File: rtl/sensor_regs.svh */
`ifndef SENSOR_REGS_SVH
`define SENSOR_REGS_SVH

// ----------------------------------------
// clock and timing
// ----------------------------------------
`define CLK_MHZ           100
`define POWERUP_MS        11
`define MEAS_8_MS         20
`define MEAS_12_MS        80
`define MEAS_14_MS        320
`define MEAS_CYC(ms)      ((ms) * 1000 * `CLK_MHZ)

// ----------------------------------------
// command byte
// ----------------------------------------
`define ADDR_OK           3'h0
`define CMD_MEAS_T        5'h03
`define CMD_MEAS_H        5'h05
`define CMD_STAT_RD       5'h07
`define CMD_STAT_WR       5'h06
`define CMD_SOFT_RST      5'h1e
`define BITS_PER_BYTE     4'h8
`define CONN_RST_LAST     4'h8

// ----------------------------------------
// status register fields
// ----------------------------------------
`define STAT_RES_BIT      0
`define STAT_NORELOAD_BIT 1
`define STAT_HEAT_BIT     2
`define STAT_LOWSUP_BIT   6
`define STAT_RESET        3'h0
`define LOWSUP_RESET      1'b0

// ----------------------------------------
// checksum
// ----------------------------------------
`define CRC_POLY          8'h31
`define CRC_INIT          8'h00

`endif

/* File: rtl/sensor_serial_if.sv */
// Behaviour
// - command is address 000 plus code
// - acknowledge low from bit 8 to 9
// - humidity 00000101, temperature 00000011 commands
// - status read 00111, write 00110
// - soft reset restores status bits 0-2 to defaults, bit 6 kept
// - measurement ends within 20/80/320 ms
// - data pulled low signals result ready
// - result held until host reads it
// - two result bytes, optional checksum, acknowledged
// - results MSB first, right justified
// - missing acknowledge ends transfer early
// - return to sleep after readout
// - nine high clocks reset interface only
// - status and measurement reads carry an 8-bit checksum
// - exactly eight status bits moved
// - status bit 0 selects resolution
// - bit 6 low supply, updated per measurement
// - host bits sampled on rising clock
// - status bit 2 turns heater on
`timescale 1ns/1ps
`include "sensor_regs.svh"

module sensor_serial_if #(
  parameter int MEAS_8_CYC  = `MEAS_CYC(`MEAS_8_MS),
  parameter int MEAS_12_CYC = `MEAS_CYC(`MEAS_12_MS),
  parameter int MEAS_14_CYC = `MEAS_CYC(`MEAS_14_MS)
) (
  input  wire logic              clock,
  input  wire logic              reset_n,
  input  wire logic              sck,
  input  wire logic              data_in,
  output logic                   data_out,
  output logic                   data_oe,
  input  wire logic              low_supply,
  input  wire logic              adc_valid,
  output logic                   adc_ready,
  input  wire sensor_pkg::word_t adc_data,
  output logic                   conv_start,
  output logic                   conv_humid,
  output logic                   conv_low_res,
  output logic                   otp_reload,
  output logic                   heater_on
);
  import sensor_pkg::*;

  // ----------------------------------------
  // pin synchronisers and edges
  // ----------------------------------------
  logic        sck_s1_ff, sck_s2_ff, sck_d_ff;
  logic        dat_s1_ff, dat_s2_ff, dat_d_ff;
  logic        sup_s1_ff, sup_s2_ff;
  logic        sck_rise, sck_fall, dat_rise, dat_fall;

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      {sck_s1_ff, sck_s2_ff, sck_d_ff} <= 3'h0;
      {dat_s1_ff, dat_s2_ff, dat_d_ff} <= 3'h7;
      {sup_s1_ff, sup_s2_ff}           <= 2'h0;
    end
    else
    begin
      {sck_s1_ff, sck_s2_ff, sck_d_ff} <= {sck, sck_s1_ff, sck_s2_ff};
      {dat_s1_ff, dat_s2_ff, dat_d_ff} <= {data_in, dat_s1_ff, dat_s2_ff};
      {sup_s1_ff, sup_s2_ff}           <= {low_supply, sup_s1_ff};
    end
  end

  assign sck_rise = sck_s2_ff & ~sck_d_ff;
  assign sck_fall = ~sck_s2_ff & sck_d_ff;
  assign dat_rise = dat_s2_ff & ~dat_d_ff;
  assign dat_fall = ~dat_s2_ff & dat_d_ff;

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  state_e      st_ff;
  logic [3:0]  cnt_ff;
  byte_t       sh_ff;
  byte_t       cmd_ff;
  logic [1:0]  bi_ff;
  logic [1:0]  nb_ff;
  logic        ack_ok_ff;
  byte_t       crc_ff;
  word_t       res_ff;
  logic [24:0] tmr_ff;
  logic [2:0]  stat_ff;
  logic        lowsup_ff;
  logic [1:0]  strt_ph_ff;
  logic [3:0]  rst_cnt_ff;
  logic        start_hit, conn_rst, cmd_ok, meas_cmd, meas_done;
  logic        buf_valid, drive_low;
  word_t       buf_data, res_mask, masked;
  logic [24:0] meas_lim;
  byte_t       stat_byte, crc_rev, next_byte;

  // ----------------------------------------
  // start sequence and connection reset
  // ----------------------------------------
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      strt_ph_ff <= 2'h0;
    else if (dat_fall && sck_s2_ff)
      strt_ph_ff <= 2'h1;
    else if (strt_ph_ff == 2'h1 && sck_fall)
      strt_ph_ff <= 2'h2;
    else if (strt_ph_ff == 2'h2 && sck_rise)
      strt_ph_ff <= 2'h3;
    else if (dat_rise || (strt_ph_ff == 2'h3 && sck_fall))
      strt_ph_ff <= 2'h0;
  end

  assign start_hit = (strt_ph_ff == 2'h3) && dat_rise && sck_s2_ff;

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      rst_cnt_ff <= 4'h0;
    else if (sck_rise)
      rst_cnt_ff <= !dat_s2_ff ? 4'h0 :
                    (rst_cnt_ff == `CONN_RST_LAST) ? rst_cnt_ff : rst_cnt_ff + 4'h1;
  end

  assign conn_rst = sck_rise && dat_s2_ff && (rst_cnt_ff == `CONN_RST_LAST);

  // ----------------------------------------
  // command decode and measurement result
  // ----------------------------------------
  assign cmd_ok = (sh_ff[7:5] == `ADDR_OK) &&
                  (sh_ff[4:0] == `CMD_MEAS_T || sh_ff[4:0] == `CMD_MEAS_H ||
                   sh_ff[4:0] == `CMD_STAT_RD || sh_ff[4:0] == `CMD_STAT_WR ||
                   sh_ff[4:0] == `CMD_SOFT_RST);
  assign meas_cmd = (cmd_ff[4:0] == `CMD_MEAS_T) || (cmd_ff[4:0] == `CMD_MEAS_H);

  always_comb
  begin
    if (cmd_ff[4:0] == `CMD_MEAS_H)
    begin
      meas_lim = stat_ff[`STAT_RES_BIT] ? 25'(MEAS_8_CYC) : 25'(MEAS_12_CYC);
      res_mask = stat_ff[`STAT_RES_BIT] ? 16'h00ff : 16'h0fff;
    end
    else
    begin
      meas_lim = stat_ff[`STAT_RES_BIT] ? 25'(MEAS_12_CYC) : 25'(MEAS_14_CYC);
      res_mask = stat_ff[`STAT_RES_BIT] ? 16'h0fff : 16'h3fff;
    end
  end

  assign meas_done = (st_ff == ST_MEAS) && (buf_valid || tmr_ff == meas_lim);
  assign masked    = buf_valid ? (buf_data & res_mask) : 16'h0000;
  assign stat_byte = {1'b0, lowsup_ff, 3'h0, stat_ff};
  assign crc_rev   = {<<{crc_ff}};

  always_comb
  begin
    if (!meas_cmd || bi_ff == 2'h1)
      next_byte = crc_rev;
    else
      next_byte = res_ff[7:0];
  end

  two_entry_buffer #(
    .WIDTH     (16)
  ) u_result_buf (
    .clock     (clock),
    .reset_n   (reset_n),
    .in_valid  (adc_valid),
    .in_ready  (adc_ready),
    .in_data   (adc_data),
    .out_valid (buf_valid),
    .out_ready (st_ff == ST_MEAS),
    .out_data  (buf_data)
  );

  function automatic byte_t crc_step(byte_t c, logic b);
    crc_step = {c[6:0], 1'b0} ^ ((c[7] ^ b) ? `CRC_POLY : 8'h00);
  endfunction

  // ----------------------------------------
  // transfer state machine
  // ----------------------------------------
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_ff     <= ST_IDLE;
      cnt_ff    <= 4'h0;
      sh_ff     <= 8'h00;
      cmd_ff    <= 8'h00;
      bi_ff     <= 2'h0;
      nb_ff     <= 2'h0;
      ack_ok_ff <= 1'b0;
      crc_ff    <= `CRC_INIT;
      res_ff    <= 16'h0000;
      tmr_ff    <= 25'h000_0000;
    end
    else if (conn_rst)
    begin
      st_ff  <= ST_IDLE;
      cnt_ff <= 4'h0;
    end
    else
    begin
      case (st_ff)
        ST_IDLE:
          if (start_hit)
          begin
            st_ff  <= ST_CMD;
            cnt_ff <= 4'h0;
            crc_ff <= `CRC_INIT;
          end
        ST_CMD:
          if (sck_rise && cnt_ff != `BITS_PER_BYTE)
          begin
            sh_ff  <= {sh_ff[6:0], dat_s2_ff};
            crc_ff <= crc_step(crc_ff, dat_s2_ff);
            cnt_ff <= cnt_ff + 4'h1;
          end
          else if (sck_fall && cnt_ff == `BITS_PER_BYTE)
          begin
            cmd_ff <= sh_ff;
            st_ff  <= cmd_ok ? ST_ACK : ST_IDLE;
          end
        ST_ACK:
          if (sck_fall)
          begin
            cnt_ff <= 4'h0;
            bi_ff  <= 2'h0;
            tmr_ff <= 25'h000_0000;
            if (meas_cmd)
              st_ff <= ST_MEAS;
            else if (cmd_ff[4:0] == `CMD_STAT_RD)
            begin
              st_ff <= ST_TX;
              sh_ff <= stat_byte;
              nb_ff <= 2'h2;
            end
            else if (cmd_ff[4:0] == `CMD_STAT_WR)
              st_ff <= ST_RX;
            else
              st_ff <= ST_IDLE;
          end
        ST_MEAS:
          if (meas_done)
          begin
            res_ff <= masked;
            sh_ff  <= masked[15:8];
            st_ff  <= ST_TX;
            nb_ff  <= 2'h3;
          end
          else
            tmr_ff <= tmr_ff + 25'h000_0001;
        ST_TX:
          if (sck_fall && cnt_ff != `BITS_PER_BYTE)
          begin
            crc_ff <= crc_step(crc_ff, sh_ff[7]);
            sh_ff  <= {sh_ff[6:0], 1'b0};
            cnt_ff <= cnt_ff + 4'h1;
          end
          else if (sck_rise && cnt_ff == `BITS_PER_BYTE)
            ack_ok_ff <= !dat_s2_ff;
          else if (sck_fall && cnt_ff == `BITS_PER_BYTE)
          begin
            if (ack_ok_ff && (bi_ff + 2'h1) != nb_ff)
            begin
              sh_ff  <= next_byte;
              bi_ff  <= bi_ff + 2'h1;
              cnt_ff <= 4'h0;
            end
            else
              st_ff <= ST_IDLE;
          end
        ST_RX:
          if (sck_rise && cnt_ff != `BITS_PER_BYTE)
          begin
            sh_ff  <= {sh_ff[6:0], dat_s2_ff};
            cnt_ff <= cnt_ff + 4'h1;
          end
          else if (sck_fall && cnt_ff == `BITS_PER_BYTE)
            st_ff <= ST_RXACK;
        ST_RXACK:
          if (sck_fall)
            st_ff <= ST_IDLE;
        default:
          st_ff <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // status register
  // ----------------------------------------
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stat_ff   <= `STAT_RESET;
      lowsup_ff <= `LOWSUP_RESET;
    end
    else
    begin
      if (st_ff == ST_ACK && sck_fall && cmd_ff[4:0] == `CMD_SOFT_RST)
        stat_ff <= `STAT_RESET;
      else if (st_ff == ST_RXACK && sck_fall)
        stat_ff <= sh_ff[2:0];
      if (meas_done)
        lowsup_ff <= sup_s2_ff;
    end
  end

  // ----------------------------------------
  // pin and converter outputs
  // ----------------------------------------
  assign drive_low = (st_ff == ST_ACK) || (st_ff == ST_RXACK) ||
                     (st_ff == ST_TX && cnt_ff != `BITS_PER_BYTE && !sh_ff[7]);

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      data_oe      <= 1'b0;
      data_out     <= 1'b1;
      conv_start   <= 1'b0;
      conv_humid   <= 1'b0;
      conv_low_res <= 1'b0;
      otp_reload   <= 1'b0;
      heater_on    <= 1'b0;
    end
    else
    begin
      data_oe      <= drive_low;
      data_out     <= ~drive_low;
      conv_start   <= (st_ff == ST_ACK) && sck_fall && meas_cmd;
      conv_humid   <= (cmd_ff[4:0] == `CMD_MEAS_H);
      conv_low_res <= stat_ff[`STAT_RES_BIT];
      otp_reload   <= (st_ff == ST_ACK) && sck_fall && meas_cmd &&
                      !stat_ff[`STAT_NORELOAD_BIT];
      heater_on    <= stat_ff[`STAT_HEAT_BIT];
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);

  AST_ACK_DRIVE: assert property (
    (st_ff == ST_CMD) && (cnt_ff == 4'h8) && sck_fall && cmd_ok |-> ##2 data_oe)
    else $error("command not acknowledged");
  AST_ACK_RELEASE: assert property (
    (st_ff == ST_ACK) && sck_fall && meas_cmd |-> ##2 !data_oe)
    else $error("acknowledge not released");
  AST_BAD_ADDR: assert property (
    (st_ff == ST_CMD) && (cnt_ff == 4'h8) && sck_fall && (sh_ff[7:5] != 3'h0)
    |=> st_ff == ST_IDLE)
    else $error("bad address accepted");
  AST_SOFT_RST: assert property (
    (st_ff == ST_ACK) && sck_fall && (cmd_ff[4:0] == 5'h1e)
    |=> (stat_ff == 3'h0) && (st_ff == ST_IDLE))
    else $error("soft reset incomplete");
  AST_MEAS_BOUND: assert property (
    (st_ff == ST_MEAS) |-> (tmr_ff <= meas_lim))
    else $error("measurement overran");
  AST_READY_LOW: assert property (
    (st_ff == ST_MEAS) ##1 (st_ff == ST_TX) |-> ##1 data_oe)
    else $error("ready not signalled");
  AST_HOLD: assert property (
    (st_ff == ST_TX) && !sck_fall && !sck_rise |=> $stable(sh_ff) && (st_ff == ST_TX))
    else $error("result not held");
  AST_NOACK_SLEEP: assert property (
    (st_ff == ST_TX) && (cnt_ff == 4'h8) && sck_fall && !ack_ok_ff |=> st_ff == ST_IDLE)
    else $error("transfer not ended");
  AST_CONN_RST: assert property (
    sck_rise && dat_s2_ff && (rst_cnt_ff == 4'h8) |=> (st_ff == ST_IDLE) && $stable(stat_ff))
    else $error("connection reset failed");
  AST_LOWSUP: assert property (
    !meas_done |=> $stable(lowsup_ff))
    else $error("low supply flag moved");

  COV_FULL_READ: cover property ((st_ff == ST_TX) && (bi_ff == 2'h2) && sck_fall &&
                                 (cnt_ff == 4'h8));
  COV_STAT_WR: cover property ((st_ff == ST_RXACK) && sck_fall);
  COV_CONN_RST: cover property (conn_rst);
  COV_TIMEOUT: cover property (meas_done && !buf_valid);

endmodule

/* File: rtl/two_entry_buffer.sv */
`timescale 1ns/1ps

module two_entry_buffer #(
  parameter int WIDTH = 16
) (
  input  wire logic             clock,
  input  wire logic             reset_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  logic [WIDTH-1:0] mem_ff [2];
  logic             wr_ptr_ff;
  logic             rd_ptr_ff;
  logic [1:0]       cnt_ff;
  logic [1:0]       nxt_cnt;
  logic             in_ready_ff;
  logic             push;
  logic             pop;

  assign push      = in_valid & in_ready_ff;
  assign pop       = out_valid & out_ready;
  assign out_valid = (cnt_ff != 2'h0);
  assign out_data  = mem_ff[rd_ptr_ff];
  assign in_ready  = in_ready_ff;

  always_comb
  begin
    nxt_cnt = cnt_ff;
    if (push && !pop)
      nxt_cnt = cnt_ff + 2'h1;
    else if (pop && !push)
      nxt_cnt = cnt_ff - 2'h1;
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_ptr_ff   <= 1'b0;
      rd_ptr_ff   <= 1'b0;
      cnt_ff      <= 2'h0;
      in_ready_ff <= 1'b1;
    end
    else
    begin
      if (push)
        wr_ptr_ff <= ~wr_ptr_ff;
      if (pop)
        rd_ptr_ff <= ~rd_ptr_ff;
      cnt_ff      <= nxt_cnt;
      in_ready_ff <= (nxt_cnt != 2'h2);
    end
  end

  always_ff @(posedge clock)
  begin
    if (push)
      mem_ff[wr_ptr_ff] <= in_data;
  end

endmodule
